// ==== rtl/iq_link_defines.svh ====
`ifndef IQ_LINK_DEFINES_SVH
`define IQ_LINK_DEFINES_SVH

// Timing
`define CLK_PERIOD_NS 40
`define LINK_PERIOD_NS 320
`define SAMPLE_DELAY_CYCLES 1

// Word layout
`define WORD_BITS 32
`define FIELD_BITS 14
`define ZERO_RUN_MIN 32
`define I_SYNC_DEFAULT 2'h2
`define Q_SYNC_DEFAULT 2'h1

// Sample rate dividers (195.3 ksample/s down to 19.5 ksample/s)
`define RATE_DIV_MIN 4'h1
`define RATE_DIV_MAX 4'hA

// Register byte offsets
`define OFF_CTRL 4'h0
`define OFF_RATE 4'h4
`define OFF_MODE 4'h8
`define OFF_STATUS 4'hC

// CTRL fields
`define CTRL_EEC_BIT 0
`define CTRL_CMHI_BIT 1
`define CTRL_CMV_LSB 2
`define CTRL_DRV_LSB 5
`define CTRL_SKEW_LSB 8

// RATE fields
`define RATE_TX_LSB 0
`define RATE_RX_LSB 8

// MODE fields
`define MODE_STATE_LSB 0
`define MODE_BAND_BIT 2

// STATUS fields
`define STAT_LOCK_BIT 0
`define STAT_OPEN_BIT 1
`define STAT_SYNCED_BIT 2
`define STAT_RXACT_BIT 3

// Reset values
`define CMV_RESET 3'h2
`define DRV_RESET 3'h2
`define SKEW_RESET 2'h0

`endif

// ==== rtl/iq_link_pkg.sv ====
package iq_link_pkg;

  typedef enum logic [1:0] {
    transceiver_off_state = 2'h0,
    transmit_prepare_state = 2'h1,
    transmit_state = 2'h3,
    receive_state = 2'h2
  } radio_state_t;

  typedef enum logic [2:0] {
    deser_hunt = 3'h0,
    deser_i_data = 3'h1,
    deser_q_sync = 3'h3,
    deser_q_data = 3'h2,
    deser_gap = 3'h6
  } deser_state_t;

  typedef struct packed {
    logic [12:0] i;
    logic [12:0] q;
  } iq_sample_t;

  typedef struct packed {
    iq_sample_t sample;
    logic ctrl;
  } tx_word_t;

endpackage

// ==== rtl/iq_serial_word_link.sv ====
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "iq_link_defines.svh"
module iq_serial_word_link
  import iq_link_pkg::*;
#(
  parameter int HALF_CYCLES = `LINK_PERIOD_NS / 2 / `CLK_PERIOD_NS,
  parameter logic [1:0] I_SYNC = `I_SYNC_DEFAULT,
  parameter logic [1:0] Q_SYNC = `Q_SYNC_DEFAULT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic baseband_forwarded_clock,
  input wire logic tx_serial_in,
  input wire logic open_input_detect,
  output logic device_forwarded_clock,
  output logic subghz_sample_out,
  output logic band2g4_sample_out,
  output logic tx_receiver_en,
  output logic device_clock_en,
  output logic subghz_drv_en,
  output logic band2g4_drv_en,
  output logic lvds_cm_high,
  output logic [2:0] lvds_cm_level,
  output logic [2:0] lvds_swing,
  input wire iq_sample_t rx_sample,
  input wire logic rx_valid,
  output logic rx_ready,
  output tx_word_t tx_sample,
  output logic tx_sample_valid
);

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
  // One cycle early: the output register adds the other
  localparam logic [7:0] MID = 8'(HALF_CYCLES / 2 - 1);
  localparam logic [5:0] ZRUN_MIN = 6'(`ZERO_RUN_MIN);

  if (HALF_CYCLES < 4 || HALF_CYCLES > 255 || (HALF_CYCLES % 2) != 0) begin : g_bad_half
    $error("HALF_CYCLES must be even and within 4..255");
  end
  if (I_SYNC == 2'h0) begin : g_bad_sync
    $error("I_SYNC must not be all zero");
  end

  typedef struct packed {
    // Configuration and status
    logic eec;
    logic cm_high;
    logic [2:0] cmv;
    logic [2:0] drv;
    logic [1:0] skew_sel;
    logic [1:0] skew_act;
    logic [3:0] tx_div;
    logic [3:0] rx_div;
    radio_state_t radio;
    logic band24;
    logic lock_flag;
    // Bus slave
    logic ph_valid;
    logic ph_write;
    logic [3:0] ph_off;
    logic [31:0] rdata;
    // Synchronisers
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    logic d_s1;
    logic d_s2;
    logic of_s1;
    logic of_s2;
    // Deserializer
    deser_state_t dstate;
    logic smp_pend;
    logic [2:0] smp_cnt;
    logic [3:0] bit_cnt;
    logic [31:0] shreg;
    logic [5:0] zrun;
    logic [5:0] zrun_prev;
    logic prev_bit;
    tx_word_t tx_out;
    logic tx_valid;
    // Serializer
    logic [7:0] half_cnt;
    logic lclk;
    logic [4:0] bit_idx;
    logic [3:0] slot;
    logic [31:0] sreg;
    logic sub_out;
    logic b24_out;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic addr_ok;
  logic tx_link_on;
  logic clk_on;
  logic rx_link_on;
  logic ck_edge;
  logic bit_take;
  logic bit_in;
  logic [1:0] pair;
  logic [31:0] sh_new;
  logic [7:0] launch_pt;
  logic launch;
  logic word_start;
  logic data_slot;
  logic [31:0] load_word;

  always_comb begin
    state_next = state_reg;

    addr_ok = hsel && hready && htrans[1];
    tx_link_on = (state_reg.radio == transmit_prepare_state) || (state_reg.radio == transmit_state);
    clk_on = tx_link_on || (state_reg.radio == receive_state);
    rx_link_on = state_reg.radio == receive_state;

    // Data phase of a write
    if (state_reg.ph_valid && state_reg.ph_write) begin
      case (state_reg.ph_off)
        `OFF_CTRL: begin
          state_next.eec = hwdata[`CTRL_EEC_BIT];
          state_next.cm_high = hwdata[`CTRL_CMHI_BIT];
          state_next.cmv = hwdata[`CTRL_CMV_LSB +: 3];
          state_next.drv = hwdata[`CTRL_DRV_LSB +: 3];
          state_next.skew_sel = hwdata[`CTRL_SKEW_LSB +: 2];
        end
        `OFF_RATE: begin
          // Out-of-range dividers are ignored, keeping the old rate
          if (hwdata[`RATE_TX_LSB +: 4] >= `RATE_DIV_MIN && hwdata[`RATE_TX_LSB +: 4] <= `RATE_DIV_MAX) begin
            state_next.tx_div = hwdata[`RATE_TX_LSB +: 4];
          end
          if (hwdata[`RATE_RX_LSB +: 4] >= `RATE_DIV_MIN && hwdata[`RATE_RX_LSB +: 4] <= `RATE_DIV_MAX) begin
            state_next.rx_div = hwdata[`RATE_RX_LSB +: 4];
          end
        end
        `OFF_MODE: begin
          state_next.radio = radio_state_t'(hwdata[`MODE_STATE_LSB +: 2]);
          state_next.band24 = hwdata[`MODE_BAND_BIT];
        end
        default: begin
        end
      endcase
    end

    // Address phase; read data reflects a write landing this cycle
    state_next.ph_valid = addr_ok;
    state_next.ph_write = addr_ok && hwrite && haddr[31:4] == 28'h000_0000;
    state_next.ph_off = addr_ok ? {haddr[3:2], 2'h0} : state_reg.ph_off;
    state_next.rdata = 32'h0000_0000;
    if (addr_ok && !hwrite && haddr[31:4] == 28'h000_0000) begin
      case ({haddr[3:2], 2'h0})
        `OFF_CTRL: begin
          state_next.rdata[`CTRL_EEC_BIT] = state_next.eec;
          state_next.rdata[`CTRL_CMHI_BIT] = state_next.cm_high;
          state_next.rdata[`CTRL_CMV_LSB +: 3] = state_next.cmv;
          state_next.rdata[`CTRL_DRV_LSB +: 3] = state_next.drv;
          state_next.rdata[`CTRL_SKEW_LSB +: 2] = state_next.skew_sel;
        end
        `OFF_RATE: begin
          state_next.rdata[`RATE_TX_LSB +: 4] = state_next.tx_div;
          state_next.rdata[`RATE_RX_LSB +: 4] = state_next.rx_div;
        end
        `OFF_MODE: begin
          state_next.rdata[`MODE_STATE_LSB +: 2] = state_next.radio;
          state_next.rdata[`MODE_BAND_BIT] = state_next.band24;
        end
        `OFF_STATUS: begin
          state_next.rdata[`STAT_LOCK_BIT] = state_reg.lock_flag;
          state_next.rdata[`STAT_OPEN_BIT] = state_reg.of_s2;
          state_next.rdata[`STAT_SYNCED_BIT] = state_reg.dstate != deser_hunt;
          state_next.rdata[`STAT_RXACT_BIT] = rx_link_on;
          state_next.lock_flag = 1'b0;
        end
        default: begin
        end
      endcase
    end
    if (!addr_ok || hwrite) begin
      state_next.rdata = state_reg.rdata;
    end

    // Skew only follows its setting while the links are down
    if (state_reg.radio == transceiver_off_state) begin
      state_next.skew_act = state_reg.skew_sel;
    end

    // Synchronisers
    state_next.ck_s1 = baseband_forwarded_clock;
    state_next.ck_s2 = state_reg.ck_s1;
    state_next.ck_s3 = state_reg.ck_s2;
    state_next.d_s1 = tx_serial_in;
    state_next.d_s2 = state_reg.d_s1;
    state_next.of_s1 = open_input_detect;
    state_next.of_s2 = state_reg.of_s1;

    // Transmit deserializer: bit taken a little after each edge of either polarity
    ck_edge = state_reg.ck_s2 != state_reg.ck_s3;
    bit_take = state_reg.smp_pend && state_reg.smp_cnt == 3'h0;
    bit_in = state_reg.d_s2;
    pair = {state_reg.prev_bit, bit_in};
    sh_new = {state_reg.shreg[30:0], bit_in};
    state_next.tx_valid = 1'b0;
    if (ck_edge) begin
      state_next.smp_pend = 1'b1;
      state_next.smp_cnt = 3'(`SAMPLE_DELAY_CYCLES);
    end else if (state_reg.smp_pend) begin
      state_next.smp_cnt = state_reg.smp_cnt - 3'h1;
      if (bit_take) begin
        state_next.smp_pend = 1'b0;
      end
    end

    if (!tx_link_on) begin
      state_next.dstate = deser_hunt;
      state_next.bit_cnt = 4'h0;
      state_next.zrun = 6'h00;
      state_next.zrun_prev = 6'h00;
      state_next.prev_bit = 1'b0;
      state_next.smp_pend = 1'b0;
    end else if (bit_take) begin
      state_next.shreg = sh_new;
      state_next.prev_bit = bit_in;
      state_next.zrun_prev = state_reg.zrun;
      if (bit_in) begin
        state_next.zrun = 6'h00;
      end else if (state_reg.zrun != 6'h3F) begin
        state_next.zrun = state_reg.zrun + 6'h01;
      end
      case (state_reg.dstate)
        deser_hunt: begin
          if (pair == I_SYNC && state_reg.zrun_prev >= ZRUN_MIN) begin
            state_next.dstate = deser_i_data;
            state_next.bit_cnt = 4'h0;
          end
        end
        deser_i_data: begin
          if (state_reg.bit_cnt == 4'(`FIELD_BITS - 1)) begin
            state_next.dstate = deser_q_sync;
            state_next.bit_cnt = 4'h0;
          end else begin
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
          end
        end
        deser_q_sync: begin
          if (state_reg.bit_cnt == 4'h1) begin
            state_next.bit_cnt = 4'h0;
            state_next.dstate = (pair == Q_SYNC) ? deser_q_data : deser_hunt;
          end else begin
            state_next.bit_cnt = 4'h1;
          end
        end
        deser_q_data: begin
          if (state_reg.bit_cnt == 4'(`FIELD_BITS - 1)) begin
            state_next.dstate = deser_gap;
            state_next.bit_cnt = 4'h0;
            state_next.zrun = 6'h00;
            state_next.tx_valid = 1'b1;
            state_next.tx_out.sample.i = sh_new[29:17];
            state_next.tx_out.sample.q = sh_new[13:1];
            state_next.tx_out.ctrl = state_reg.eec && sh_new[16];
            state_next.lock_flag = 1'b1;
          end else begin
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
          end
        end
        deser_gap: begin
          // Back-to-back word keeps lock; a zero gap or anything else drops back to hunt
          if (state_reg.bit_cnt == 4'h1) begin
            state_next.bit_cnt = 4'h0;
            state_next.dstate = (pair == I_SYNC) ? deser_i_data : deser_hunt;
          end else begin
            state_next.bit_cnt = 4'h1;
          end
        end
        default: begin
          state_next.dstate = deser_hunt;
        end
      endcase
    end

    // Receive clock from a divider of hclk; data changes midway between edges, later by skew_act cycles up to the next edge
    launch_pt = MID + {6'h00, state_reg.skew_act};
    if (launch_pt > HALF_LAST) begin
      launch_pt = HALF_LAST;
    end
    launch = clk_on && state_reg.half_cnt == launch_pt;
    word_start = launch && state_reg.bit_idx == 5'h00 && !state_reg.lclk;
    data_slot = state_reg.slot == 4'h0;
    rx_ready = rx_link_on && word_start && data_slot;
    load_word = 32'h0000_0000;
    if (rx_ready && rx_valid) begin
      load_word = {I_SYNC, rx_sample.i, 1'b0, Q_SYNC, rx_sample.q, 1'b0};
    end
    if (!clk_on) begin
      state_next.half_cnt = 8'h00;
      state_next.lclk = 1'b0;
      state_next.bit_idx = 5'h00;
      state_next.slot = 4'h0;
      state_next.sreg = 32'h0000_0000;
      state_next.sub_out = 1'b0;
      state_next.b24_out = 1'b0;
    end else begin
      if (state_reg.half_cnt == HALF_LAST) begin
        state_next.half_cnt = 8'h00;
        state_next.lclk = !state_reg.lclk;
      end else begin
        state_next.half_cnt = state_reg.half_cnt + 8'h01;
      end
      if (launch) begin
        state_next.bit_idx = state_reg.bit_idx + 5'h01;
        if (word_start) begin
          state_next.sreg = {load_word[30:0], 1'b0};
          state_next.sub_out = rx_link_on && !state_reg.band24 && load_word[31];
          state_next.b24_out = rx_link_on && state_reg.band24 && load_word[31];
          state_next.slot = (state_reg.slot >= state_reg.rx_div - 4'h1) ? 4'h0 : state_reg.slot + 4'h1;
        end else begin
          state_next.sreg = {state_reg.sreg[30:0], 1'b0};
          state_next.sub_out = rx_link_on && !state_reg.band24 && state_reg.sreg[31];
          state_next.b24_out = rx_link_on && state_reg.band24 && state_reg.sreg[31];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
      state_reg.cmv <= `CMV_RESET;
      state_reg.drv <= `DRV_RESET;
      state_reg.skew_sel <= `SKEW_RESET;
      state_reg.skew_act <= `SKEW_RESET;
      state_reg.tx_div <= `RATE_DIV_MIN;
      state_reg.rx_div <= `RATE_DIV_MIN;
      state_reg.radio <= transceiver_off_state;
      state_reg.dstate <= deser_hunt;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;
  assign device_forwarded_clock = state_reg.lclk;
  assign subghz_sample_out = state_reg.sub_out;
  assign band2g4_sample_out = state_reg.b24_out;
  assign tx_receiver_en = tx_link_on;
  assign device_clock_en = clk_on;
  assign subghz_drv_en = rx_link_on && !state_reg.band24;
  assign band2g4_drv_en = rx_link_on && state_reg.band24;
  assign lvds_cm_high = state_reg.cm_high;
  assign lvds_cm_level = state_reg.cm_high ? 3'h0 : state_reg.cmv;
  assign lvds_swing = state_reg.drv;
  assign tx_sample = state_reg.tx_out;
  assign tx_sample_valid = state_reg.tx_valid;

endmodule // iq_serial_word_link

// ==== tb/iq_serial_word_link_properties.sv ====
`timescale 1ns/100ps
module iq_link_checker
  import iq_link_pkg::*;
#(
  parameter int HALF_CYCLES = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic device_forwarded_clock,
  input wire logic subghz_sample_out,
  input wire logic band2g4_sample_out,
  input wire logic tx_receiver_en,
  input wire logic device_clock_en,
  input wire logic subghz_drv_en,
  input wire logic band2g4_drv_en,
  input wire logic lvds_cm_high,
  input wire logic [2:0] lvds_cm_level,
  input wire logic rx_ready,
  input wire logic rx_valid,
  input wire tx_word_t tx_sample,
  input wire logic tx_sample_valid
);
  logic clk_q, seen_q, tgl, rx_en, dat;
  logic [7:0] run_q;
  assign tgl = device_forwarded_clock != clk_q;
  assign rx_en = subghz_drv_en || band2g4_drv_en;
  assign dat = subghz_sample_out || band2g4_sample_out;
  // First toggle after enable counts one cycle long, so it is not judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_q <= 1'b0;
      seen_q <= 1'b0;
      run_q <= 8'h00;
    end else begin
      clk_q <= device_forwarded_clock;
      seen_q <= device_clock_en && (seen_q || tgl);
      run_q <= (!device_clock_en || tgl) ? 8'h01 : run_q + 8'h01;
    end
  end
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_HALF_PERIOD: assert property (tgl && seen_q && device_clock_en |-> run_q == 8'(HALF_CYCLES))
    else $error("bad half period");
  AST_TX_LINK: assert property (tx_receiver_en |-> device_clock_en && !rx_en)
    else $error("bad transmit link enables");
  AST_QUIET_SUB: assert property (!subghz_drv_en && !$past(subghz_drv_en) |-> !subghz_sample_out)
    else $error("idle output not low");
  AST_QUIET_B24: assert property (!band2g4_drv_en && !$past(band2g4_drv_en) |-> !band2g4_sample_out)
    else $error("idle output not low");
  // Bench keeps the skew setting at zero
  AST_CENTRED: assert property (rx_en && seen_q && $changed(dat) |-> run_q == 8'(HALF_CYCLES / 2))
    else $error("data moves with clock");
  AST_SYNC_LEAD: assert property (rx_ready && rx_valid && rx_en |=> dat ##4 !dat)
    else $error("bad word lead");
  AST_RX_ONLY: assert property (rx_ready |-> rx_en)
    else $error("slot outside receive");
  AST_CM_OVERRIDE: assert property (lvds_cm_high |-> lvds_cm_level == 3'h0)
    else $error("level not overridden");
  AST_WORD_PULSE: assert property (tx_sample_valid |-> tx_receiver_en ##1 !tx_sample_valid)
    else $error("bad word pulse");
  AST_WORD_HOLD: assert property ($changed(tx_sample) |-> tx_sample_valid)
    else $error("word changed alone");
  C_RX_SUB: cover property (rx_ready && subghz_drv_en);
  C_RX_B24: cover property (rx_ready && band2g4_drv_en);
  C_WORD: cover property (tx_sample_valid);
endmodule // iq_link_checker

bind iq_serial_word_link iq_link_checker #(.HALF_CYCLES(HALF_CYCLES)) u_checker (.*);

// ==== tb/baseband_model.sv ====
`timescale 1ns/100ps
module baseband_model (
  output logic link_clk,
  output logic link_data,
  input wire logic dev_clk,
  input wire logic dev_data
);
  logic [31:0] rxq[$];
  logic [31:0] rx_sr;
  int rx_cnt;
  initial begin
    link_clk = 1'b0;
    link_data = 1'b1;
    rx_sr = 32'h0;
  end
  // Same period as the device clock, phase left free
  task automatic send(input logic [31:0] w);
    for (int b = 31; b > 0; b -= 2) begin
      link_data = w[b];
      link_clk = 1'b1;
      #160;
      link_data = w[b - 1];
      link_clk = 1'b0;
      #160;
    end
  endtask
  // Released line goes to the pull-up; clock stands still
  task automatic idle();
    link_data = 1'b1;
  endtask
  // Word starts at the first one after zero words
  always @(posedge dev_clk or negedge dev_clk) begin
    if (rx_cnt > 0 || dev_data === 1'b1) begin
      rx_sr = {rx_sr[30:0], dev_data};
      rx_cnt++;
    end
    if (rx_cnt == 32) begin
      rxq.push_back(rx_sr);
      rx_cnt = 0;
    end
  end
endmodule // baseband_model

// ==== tb/iq_serial_word_link_tb_top.sv ====
`timescale 1ns/100ps
module iq_serial_word_link_tb_top;
  import iq_link_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, baseband_forwarded_clock, tx_serial_in;
  logic open_input_detect, device_forwarded_clock, subghz_sample_out, band2g4_sample_out, tx_receiver_en;
  logic device_clock_en, subghz_drv_en, band2g4_drv_en, lvds_cm_high, rx_valid, rx_ready, tx_sample_valid;
  logic [31:0] haddr, hwdata, hrdata, rd, w;
  logic [2:0] hsize, lvds_cm_level, lvds_swing;
  logic [1:0] htrans;
  logic [12:0] i, q;
  logic c;
  iq_sample_t rx_sample;
  tx_word_t tx_sample;
  tx_word_t txq[$];
  logic [31:0] rxe[$];
  logic [31:0] rst_tab[5] = '{32'h48, 32'h101, 32'h0, 32'h0, 32'h0};
  int plan[10] = '{0, 0, 1, 1, 0, 1, 2, 3, 0, 1};
  int err_count, cmp_count, cyc, last_rdy, rx_div;
  assign hready = hreadyout;
  iq_serial_word_link #(.HALF_CYCLES(4)) DUT (.*);
  baseband_model bb (
    .link_clk(baseband_forwarded_clock),
    .link_data(tx_serial_in),
    .dev_clk(device_forwarded_clock),
    .dev_data(subghz_sample_out | band2g4_sample_out)
  );
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Reference model of both streams, checked at every result
  always @(posedge hclk) begin
    cyc++;
    if (tx_sample_valid === 1'b1) begin
      chk(32'(tx_sample), txq.size() > 0 ? 32'(txq.pop_front()) : 32'hFFFFFFFF);
    end
    if (rx_ready === 1'b1) begin
      if (rx_div > 0 && last_rdy > 0) chk(32'(cyc - last_rdy), 32'(128 * rx_div));
      last_rdy = cyc;
      if (rx_valid) rxe.push_back({2'h2, rx_sample.i, 1'b0, 2'h1, rx_sample.q, 1'b0});
      rx_sample <= iq_sample_t'(26'($urandom));
      rx_valid <= ($urandom % 4) != 0;
    end
  end
  initial begin
    #2000000;
    err_count++;
    $display("watchdog expired");
    final_report();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    open_input_detect = 1'b0;
    rx_valid = 1'b0;
    rx_sample = '0;
    void'($urandom(36));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rst_tab[k]) begin
      bus(1'b0, 32'(4 * k), 32'h0);
      chk(rd, rst_tab[k]);
    end
    chk(32'({lvds_cm_high, lvds_cm_level, lvds_swing}), 32'h12);
    $display("reset done");
    for (int k = 0; k < 2; k++) begin
      w = ($urandom & 32'hFC) | 32'(k << 1);
      bus(1'b1, 32'h0, w);
      @(posedge hclk);
      chk(32'({lvds_cm_high, lvds_cm_level, lvds_swing}), 32'({w[1], k ? 3'h0 : w[4:2], w[7:5]}));
    end
    $display("level done");
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 32'h8, 32'(m));
      @(posedge hclk);
      w = 32'({m[0], m[1:0] != 0, m[1:0] == 2 && !m[2], m[1:0] == 2 && m[2]});
      chk(32'({tx_receiver_en, device_clock_en, subghz_drv_en, band2g4_drv_en}), w);
    end
    $display("mode done");
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, 32'h0, 32'h48 | 32'(e));
      bus(1'b1, 32'h8, 32'h3);
      #7;
      // Broken Q sync, then a word with no zero run before it
      foreach (plan[n]) begin
        i = 13'($urandom);
        q = 13'($urandom);
        c = 1'($urandom);
        w = plan[n] == 0 ? 32'h0 : {2'h2, i, c, plan[n] == 2 ? 2'h3 : 2'h1, q, 1'b0};
        if (plan[n] == 1) txq.push_back({i, q, c & e[0]});
        bb.send(w);
      end
      bb.idle();
      bus(1'b0, 32'hC, 32'h0);
      chk(32'(rd[0]), 32'h1);
      bus(1'b0, 32'hC, 32'h0);
      chk(32'(rd[0]), 32'h0);
      chk(32'(txq.size()), 32'h0);
      $display("transmit done");
    end
    bus(1'b1, 32'h8, 32'h0);
    for (int k = 1; k >= 0; k--) begin
      open_input_detect <= 1'(k);
      repeat (4) @(posedge hclk);
      bus(1'b0, 32'hC, 32'h0);
      chk(32'(rd[1]), 32'(k));
    end
    $display("open input done");
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 32'h4, 32'h1 | 32'(k * 2 + 1) << 8);
      rxe.delete();
      bb.rxq.delete();
      bb.rx_cnt = 0;
      last_rdy = 0;
      rx_div = k * 2 + 1;
      bus(1'b1, 32'h8, 32'h2 | 32'(k << 2));
      repeat (1600) @(posedge hclk);
      bus(1'b1, 32'h8, 32'h0);
      rx_div = 0;
      chk(32'(bb.rxq.size() > 1), 32'h1);
      while (bb.rxq.size() > 0) chk(bb.rxq.pop_front(), rxe.size() > 0 ? rxe.pop_front() : 32'h0);
      $display("receive done");
    end
    bus(1'b1, 32'h4, 32'h0000_0B00);
    bus(1'b0, 32'h4, 32'h0);
    chk(rd, 32'h301);
    $display("rate limit done");
    final_report();
  end
endmodule // iq_serial_word_link_tb_top
